// ===== dcsc_cfg.svh
// Register offsets, field positions and reset values for the converter control block
`ifndef DCSC_CFG_SVH
`define DCSC_CFG_SVH
// Byte offsets of the register words
`define DCSC_OFF_CR0     12'h000
`define DCSC_OFF_CR1     12'h004
`define DCSC_OFF_GSW     12'h008
`define DCSC_OFF_LSW     12'h00c
`define DCSC_OFF_MSW     12'h010
`define DCSC_OFF_STB     12'h014
`define DCSC_OFF_CODE    12'h018
`define DCSC_OFF_TRIM    12'h01c
`define DCSC_OFF_STAT    12'h020
// Field positions
`define DCSC_CR0_MODE    4
`define DCSC_CR0_RNG_HI  3
`define DCSC_CR0_RNG_LO  2
`define DCSC_CR1_SRC     5
`define DCSC_CR1_DIRSEL  3
`define DCSC_CR1_DIR     2
`define DCSC_STB_EN      3
`define DCSC_STB_SEL_HI  2
`define DCSC_STB_SEL_LO  0
// Strobe source codes
`define DCSC_SEL_BUSWR   3'h0
`define DCSC_SEL_ACLK    3'h1
`define DCSC_SEL_FAB0    3'h2
// Reset values
`define DCSC_RST_BYTE    8'h00
`endif

// ===== dcsc_pkg.sv
// Types shared by the converter control block
package dcsc_pkg;
	// Strobe edge detector states, one-hot
	typedef enum logic [1:0] {
		DCSC_ST_LOW  = 2'b01,
		DCSC_ST_HIGH = 2'b10
	} dcsc_edge_t;
endpackage : dcsc_pkg

// ===== dcsc_sync.sv
// Two-flop synchroniser for a vector of outside inputs
module dcsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage

	// Refuse a meaningless width
	if (WIDTH < 1) begin : g_chk
		$error("dcsc_sync: WIDTH must be at least 1");
	end

	// Two stages against metastability
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule : dcsc_sync

// ===== dcsc_top.sv
// Converter control block: APB registers, code source, strobe and routing selects
`include "dcsc_cfg.svh"

// How it works
// - Code from register or fabric lines
// - Strobe enabled: output changes only on strobe
// - Strobe source field picks bus, clock, fabric
// - Control bit selects current or voltage mode
// - Current mode: range field picks three scales
// - Voltage mode: range field picks two scales
// - Each range has 255 equal steps
// - Direction bit, or fabric when enabled
// - Routing registers drive three route select outputs
module dcsc_top #(
	parameter int CODE_W = 8, // Code width
	parameter int FAB_STB = 6  // Number of fabric strobe lines
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [CODE_W-1:0] fabric_code,
	input  wire logic [FAB_STB-1:0] fabric_strobe,
	input  wire logic              fabric_dir,
	input  wire logic              analog_clk_strobe,
	output logic      [CODE_W-1:0] dac_code,
	output logic                   current_output_mode,
	output logic      [1:0]        range_sel,
	output logic                   sink_sel,
	output logic      [7:0]        global_route_select,
	output logic      [7:0]        local_route_select,
	output logic      [7:0]        muxbus_route_select,
	output logic      [7:0]        gain_trim
);
	// Refuse widths the register map cannot hold
	if (CODE_W != 8 || FAB_STB < 1 || FAB_STB > 6) begin : g_chk
		$error("dcsc_top: unsupported parameters");
	end

	// Software registers
	logic [7:0]  cr0_reg;              // Mode and range
	logic [7:0]  cr1_reg;              // Source and direction
	logic [7:0]  gsw_reg;              // Global route select
	logic [7:0]  lsw_reg;              // Local route select
	logic [7:0]  msw_reg;              // Mux bus route select
	logic [7:0]  stb_reg;              // Strobe control
	logic [7:0]  code_reg;             // Software code
	logic [7:0]  trim_reg;             // Gain trim
	logic [CODE_W-1:0] out_code_reg;   // Code applied to converter
	logic        bus_wr_pulse_reg;     // Code register was just written
	logic        dir_reg;              // Registered direction
	dcsc_pkg::dcsc_edge_t edge_reg;    // Strobe edge state
	dcsc_pkg::dcsc_edge_t edge_next;   // Next strobe edge state

	// Outside inputs brought into pclk domain
	logic [CODE_W-1:0]  fab_code_s;
	logic [FAB_STB-1:0] fab_stb_s;
	logic               fab_dir_s;
	logic               aclk_s;

	dcsc_sync #(.WIDTH(CODE_W + FAB_STB + 2)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({fabric_code, fabric_strobe, fabric_dir, analog_clk_strobe}),
		.dout    ({fab_code_s, fab_stb_s, fab_dir_s, aclk_s})
	);

	// Bus decode; one-wait-free access, answered in the access phase
	wire         acc      = psel & penable;
	wire         wr_en    = acc & pwrite;
	wire         hit_cr0  = (paddr == `DCSC_OFF_CR0);
	wire         hit_cr1  = (paddr == `DCSC_OFF_CR1);
	wire         hit_gsw  = (paddr == `DCSC_OFF_GSW);
	wire         hit_lsw  = (paddr == `DCSC_OFF_LSW);
	wire         hit_msw  = (paddr == `DCSC_OFF_MSW);
	wire         hit_stb  = (paddr == `DCSC_OFF_STB);
	wire         hit_code = (paddr == `DCSC_OFF_CODE);
	wire         hit_trim = (paddr == `DCSC_OFF_TRIM);
	wire         hit_stat = (paddr == `DCSC_OFF_STAT);
	wire         mapped   = hit_cr0 | hit_cr1 | hit_gsw | hit_lsw | hit_msw |
	                        hit_stb | hit_code | hit_trim | hit_stat;
	wire         setup    = psel & ~penable;

	// Read mux; status shows the code actually applied and the registered direction
	wire [7:0] rd_byte =
		hit_cr0  ? cr0_reg  :
		hit_cr1  ? cr1_reg  :
		hit_gsw  ? gsw_reg  :
		hit_lsw  ? lsw_reg  :
		hit_msw  ? msw_reg  :
		hit_stb  ? stb_reg  :
		hit_code ? code_reg :
		hit_trim ? trim_reg :
		hit_stat ? out_code_reg : `DCSC_RST_BYTE;
	wire [31:0] rd_word = hit_stat ? {23'h000000, dir_reg, out_code_reg} : {24'h000000, rd_byte};

	// Code source choice
	wire               src_fabric = cr1_reg[`DCSC_CR1_SRC];
	wire [CODE_W-1:0]  sel_code   = src_fabric ? fab_code_s : code_reg;
	// Shared bus: only one converter drives fabric_code at a time, so the sampled value is trusted
	// as this converter's code whenever fabric source is chosen.

	// Strobe source select
	wire [2:0] stb_sel = stb_reg[`DCSC_STB_SEL_HI:`DCSC_STB_SEL_LO];
	wire [2:0] fab_idx = stb_sel - `DCSC_SEL_FAB0;
	wire       fab_lvl = (stb_sel >= `DCSC_SEL_FAB0) && (int'(fab_idx) < FAB_STB) ? fab_stb_s[fab_idx] : 1'b0;
	wire       lvl_stb = (stb_sel == `DCSC_SEL_ACLK) ? aclk_s : fab_lvl;
	// Limitation: switching to a source whose line is already high reads as a rising edge,
	// so firmware should change the source while the strobe lines are quiet
	wire       lvl_rise = (edge_reg == dcsc_pkg::DCSC_ST_LOW) && lvl_stb;
	wire       strobe_evt = (stb_sel == `DCSC_SEL_BUSWR) ? bus_wr_pulse_reg : lvl_rise;
	wire       stb_en = stb_reg[`DCSC_STB_EN];
	// With strobing on, load only on the event; otherwise follow the source
	wire       load_code = stb_en ? strobe_evt : 1'b1;

	// Direction, from register bit or fabric line
	wire       dir_sel = cr1_reg[`DCSC_CR1_DIRSEL] ? fab_dir_s : cr1_reg[`DCSC_CR1_DIR];

	// Edge detector for level strobes
	always_comb begin
		case (edge_reg)
			dcsc_pkg::DCSC_ST_LOW:  edge_next = lvl_stb ? dcsc_pkg::DCSC_ST_HIGH : dcsc_pkg::DCSC_ST_LOW;
			dcsc_pkg::DCSC_ST_HIGH: edge_next = lvl_stb ? dcsc_pkg::DCSC_ST_HIGH : dcsc_pkg::DCSC_ST_LOW;
			default:                edge_next = dcsc_pkg::DCSC_ST_LOW;
		endcase
	end

	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cr0_reg  <= `DCSC_RST_BYTE;
			cr1_reg  <= `DCSC_RST_BYTE;
			gsw_reg  <= `DCSC_RST_BYTE;
			lsw_reg  <= `DCSC_RST_BYTE;
			msw_reg  <= `DCSC_RST_BYTE;
			stb_reg  <= `DCSC_RST_BYTE;
			code_reg <= `DCSC_RST_BYTE;
			trim_reg <= `DCSC_RST_BYTE;
		end else if (wr_en) begin
			if (hit_cr0)  cr0_reg  <= pwdata[7:0];
			if (hit_cr1)  cr1_reg  <= pwdata[7:0];
			if (hit_gsw)  gsw_reg  <= pwdata[7:0];
			if (hit_lsw)  lsw_reg  <= pwdata[7:0];
			if (hit_msw)  msw_reg  <= pwdata[7:0];
			if (hit_stb)  stb_reg  <= pwdata[7:0];
			if (hit_code) code_reg <= pwdata[7:0];
			if (hit_trim) trim_reg <= pwdata[7:0];
		end
	end

	// Bus write strobe fires the cycle after the code word lands, so the new value is loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_wr_pulse_reg <= 1'b0;
		end else begin
			bus_wr_pulse_reg <= wr_en & hit_code;
		end
	end

	// Applied code and edge state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_code_reg <= '0;
			edge_reg     <= dcsc_pkg::DCSC_ST_LOW;
			dir_reg      <= 1'b0;
		end else begin
			edge_reg <= edge_next;
			dir_reg  <= dir_sel;
			if (load_code) begin
				out_code_reg <= sel_code;
			end
		end
	end

	// APB answer; slave never stalls, unmapped gives error and zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	// Analog-facing outputs, all registered.
	// Code scales linearly: step = full scale / 256, 255 steps per range
	// Rate limits are kept by the fabric or firmware pacing updates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_code            <= '0;
			current_output_mode <= 1'b0;
			range_sel           <= 2'b00;
			sink_sel            <= 1'b0;
			global_route_select <= `DCSC_RST_BYTE;
			local_route_select  <= `DCSC_RST_BYTE;
			muxbus_route_select <= `DCSC_RST_BYTE;
			gain_trim           <= `DCSC_RST_BYTE;
		end else begin
			dac_code            <= out_code_reg;
			current_output_mode <= cr0_reg[`DCSC_CR0_MODE];
			range_sel           <= cr0_reg[`DCSC_CR0_RNG_HI:`DCSC_CR0_RNG_LO];
			sink_sel            <= dir_reg;
			global_route_select <= gsw_reg;
			local_route_select  <= lsw_reg;
			muxbus_route_select <= msw_reg;
			gain_trim           <= trim_reg;
		end
	end
endmodule : dcsc_top

// ===== dcsc_props.sv
// Concurrent checks on the converter control block ports
module dcsc_props #(
	parameter int CODE_W  = 8, // Code width
	parameter int FAB_STB = 6  // Fabric strobe lines
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [11:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic [CODE_W-1:0]  fabric_code,
	input wire logic [FAB_STB-1:0] fabric_strobe,
	input wire logic               analog_clk_strobe,
	input wire logic [CODE_W-1:0]  dac_code,
	input wire logic               current_output_mode,
	input wire logic [1:0]         range_sel,
	input wire logic               sink_sel,
	input wire logic [7:0]         global_route_select
);
	timeunit 1ns / 1ps;
	logic              wr;      // Completed APB write
	logic [5:0]        cr1_q;   // Shadow of second control word
	logic [3:0]        stb_q;   // Shadow of strobe word
	logic [CODE_W-1:0] wcode_q; // Last code register write
	assign wr = psel && penable && pwrite && pready;
	// Shadows move only on completed writes, as the registers do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cr1_q   <= '0;
			stb_q   <= '0;
			wcode_q <= '0;
		end else begin
			if (wr && paddr == 12'h004) cr1_q <= pwdata[5:0];
			if (wr && paddr == 12'h014) stb_q <= pwdata[3:0];
			if (wr && paddr == 12'h018) wcode_q <= pwdata[CODE_W-1:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Strobe armed on a non-bus source and every strobe input quiet
	sequence s_quiet; (stb_q[3] && stb_q[2:0] != 3'h0 && !analog_clk_strobe && fabric_strobe == '0)[*6]; endsequence
	// Fabric source, strobe off, code lines steady
	sequence s_fab; (cr1_q[5] && !stb_q[3] && $stable(fabric_code))[*6]; endsequence
	property p_mode; wr && paddr == 12'h000 |-> ##2 current_output_mode == $past(pwdata[4], 2); endproperty
	a_mode: assert property (p_mode) else $error("mode bit not applied");
	property p_rng; wr && paddr == 12'h000 |-> ##2 range_sel == $past(pwdata[3:2], 2); endproperty
	a_rng: assert property (p_rng) else $error("range field not applied");
	property p_route; wr && paddr == 12'h008 |-> ##2 global_route_select == $past(pwdata[7:0], 2); endproperty
	a_route: assert property (p_route) else $error("route select not applied");
	property p_dir; wr && paddr == 12'h004 && !pwdata[3] |-> ##3 sink_sel == $past(pwdata[2], 3); endproperty
	a_dir: assert property (p_dir) else $error("direction bit not applied");
	property p_hold; s_quiet |-> $stable(dac_code); endproperty
	a_hold: assert property (p_hold) else $error("code moved without strobe");
	property p_sel; stb_q == 4'h9 && cr1_q[5] && $rose(analog_clk_strobe) |-> ##[1:8] dac_code == fabric_code; endproperty
	a_sel: assert property (p_sel) else $error("clock strobe did not load");
	property p_direct; wr && paddr == 12'h018 && !stb_q[3] && !cr1_q[5] |=> ##[0:3] dac_code == wcode_q; endproperty
	a_direct: assert property (p_direct) else $error("code write not applied");
	property p_fab; s_fab |-> dac_code == fabric_code; endproperty
	a_fab: assert property (p_fab) else $error("fabric code not followed");
endmodule : dcsc_props
bind dcsc_top dcsc_props #(.CODE_W(CODE_W), .FAB_STB(FAB_STB)) PROPS (.*);

// ===== dcsc_fabric_model.sv
// Fabric-side model: code lines, strobes and direction input
module dcsc_fabric_model (
	input  wire logic       pclk,
	output logic      [7:0] fabric_code,
	output logic      [5:0] fabric_strobe,
	output logic            fabric_dir,
	output logic            analog_clk_strobe
);
	timeunit 1ns / 1ps;
	// Only this model drives the shared code bus, always fully
	initial {fabric_code, fabric_strobe, fabric_dir, analog_clk_strobe} = '0;
	// New code and direction, changed just after an edge
	task automatic set(input logic [7:0] c, input logic d);
		@(posedge pclk);
		fabric_code <= c;
		fabric_dir  <= d;
	endtask : set
	// Strobe held 3 cycles so the synchroniser sees it, then a long gap
	task automatic pulse(input int s);
		@(posedge pclk);
		if (s == 1) analog_clk_strobe <= 1'b1;
		else fabric_strobe[s-2] <= 1'b1;
		repeat (3) @(posedge pclk);
		analog_clk_strobe <= 1'b0;
		fabric_strobe     <= 6'h00;
		repeat (8) @(posedge pclk);
	endtask : pulse
endmodule : dcsc_fabric_model

// ===== dac_code_strobe_control_bench.sv
// Self-checking bench for the converter control block
module dac_code_strobe_control_bench;
	timeunit 1ns / 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  fabric_code, dac_code, global_route_select, local_route_select, muxbus_route_select, gain_trim, prev;
	logic [5:0]  fabric_strobe;
	logic [1:0]  range_sel;
	logic        fabric_dir, analog_clk_strobe, current_output_mode, sink_sel;
	int          miscompares = 0, num_checks = 0, cycles = 0;
	dcsc_top DUT (.*);
	dcsc_fabric_model FAB (.*);
	always #20 pclk = ~pclk;
	// Hang guard: the whole sequence needs well under 3000 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			test_done();
		end
	end
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the hang guard ends a stuck wait
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Let outputs settle past the edge
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wt
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Every word reads zero after reset; past the map is refused
		for (int a = 0; a <= 32; a += 4) begin
			apb(1'b0, 12'(a), 32'h0);
			check(rd | 32'(err), 32'h0);
		end
		apb(1'b0, 12'h024, 32'h0);
		check({err, rd[30:0]}, 32'h80000000);
		$display("reset and decode test done");
		// All mode and range codes
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, 12'h000, 32'(m << 2));
			wt(1);
			check({29'h0, current_output_mode, range_sel}, 32'(m));
		end
		apb(1'b1, 12'h008, 32'h5a);
		apb(1'b1, 12'h00c, 32'hc3);
		apb(1'b1, 12'h010, 32'h81);
		apb(1'b1, 12'h01c, 32'h7e);
		wt(1);
		check({global_route_select, local_route_select, muxbus_route_select, gain_trim}, 32'h5ac3817e);
		apb(1'b0, 12'h008, 32'h0);
		check(rd, 32'h0000005a);
		$display("mode and route test done");
		// Direction from the bit, then handed to the fabric line
		apb(1'b1, 12'h004, 32'h04);
		wt(2);
		check(32'(sink_sel), 32'h1);
		apb(1'b1, 12'h004, 32'h08);
		wt(4);
		check(32'(sink_sel), 32'h0);
		FAB.set(8'h00, 1'b1);
		wt(4);
		apb(1'b0, 12'h020, 32'h0);
		check({rd[8], sink_sel}, 2'b11);
		// Strobe off: code writes act at once, both end codes included
		apb(1'b1, 12'h004, 32'h00);
		for (int i = 0; i < 3; i++) begin
			prev = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'ha5;
			apb(1'b1, 12'h018, 32'(prev));
			wt(4);
			check(dac_code, prev);
		end
		// Fabric source ignores the code register
		FAB.set(8'h3c, 1'b0);
		apb(1'b1, 12'h004, 32'h20);
		apb(1'b1, 12'h018, 32'h11);
		wt(6);
		check(dac_code, 8'h3c);
		$display("direction and source test done");
		// Each non-bus strobe source: hold until its own strobe
		prev = 8'h3c;
		for (int s = 1; s < 8; s++) begin
			apb(1'b1, 12'h014, 32'(8 + s));
			FAB.set(8'h40 + 8'(s), 1'b1);
			wt(8);
			check(dac_code, prev);
			FAB.pulse(s);
			wt(1);
			prev = 8'h40 + 8'(s);
			check(dac_code, prev);
		end
		// Source switch under strobe holds; bus write strobe then loads
		apb(1'b1, 12'h004, 32'h00);
		wt(4);
		check(dac_code, prev);
		apb(1'b1, 12'h014, 32'h08);
		apb(1'b1, 12'h018, 32'h99);
		wt(4);
		check(dac_code, 8'h99);
		$display("strobe test done");
		test_done();
	end
endmodule : dac_code_strobe_control_bench
